// ---- smsp_pkg.sv ----
package smsp_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // register addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h2c;
    localparam logic [7:0] ADDR_STATUS  = 8'h2d;
    localparam logic [7:0] ADDR_DATA    = 8'h2e;

    // serial_control fields
    localparam int unsigned CTRL_DONE_IRQ_EN = 7;
    localparam int unsigned CTRL_PORT_EN     = 6;
    localparam int unsigned CTRL_LSB_FIRST   = 5;
    localparam int unsigned CTRL_CONTROLLER  = 4;
    localparam int unsigned CTRL_IDLE_LEVEL  = 3;
    localparam int unsigned CTRL_PHASE       = 2;
    localparam int unsigned CTRL_RATE_HIGH   = 1;
    localparam int unsigned CTRL_RATE_LOW    = 0;

    // serial_status fields
    localparam int unsigned STAT_DONE        = 7;
    localparam int unsigned STAT_COLLISION   = 6;
    localparam int unsigned STAT_RATE_DOUBLE = 0;

    localparam logic [7:0] CONTROL_RESET     = 8'h00;
    localparam logic       RATE_DOUBLE_RESET = 1'b0;
    localparam logic [7:0] DATA_RESET        = 8'h00;

    // system clocks per half period of the generated serial clock,
    // indexed by {rate_double, rate_select_high, rate_select_low}
    localparam logic [6:0] HALF_DIV [8] = '{7'h02, 7'h08, 7'h20, 7'h40,
                                           7'h01, 7'h04, 7'h10, 7'h20};

    localparam logic [3:0] LAST_HALF_EDGE = 4'hf;
    localparam logic [3:0] LAST_BIT       = 4'h7;

    // synchroniser lanes
    localparam int unsigned SYNC_W    = 4;
    localparam int unsigned SYNC_SCK  = 0;
    localparam int unsigned SYNC_MOSI = 1;
    localparam int unsigned SYNC_MISO = 2;
    localparam int unsigned SYNC_SS   = 3;

    typedef enum logic [1:0] {
        XFER_IDLE,
        XFER_MASTER,
        XFER_SLAVE
    } smsp_xfer_e;

endpackage : smsp_pkg

// ---- smsp_sync.sv ----
module smsp_sync (
    input  wire logic                          i_clock,
    input  wire logic                          i_rst_n,
    input  wire logic [smsp_pkg::SYNC_W-1:0]   i_async,
    output logic      [smsp_pkg::SYNC_W-1:0]   o_sync
);
    import smsp_pkg::*;

    typedef struct packed {
        logic [SYNC_W-1:0] meta;
        logic [SYNC_W-1:0] sync;
    } smsp_sync_s;

    smsp_sync_s s_q;
    smsp_sync_s s_d;
    logic [SYNC_W-1:0] meta_d;
    logic [SYNC_W-1:0] sync_d;

    // the first stage feeds only the second stage
    for (genvar g = 0; g < SYNC_W; g++) begin : g_lane
        assign meta_d[g] = i_async[g];
        assign sync_d[g] = s_q.meta[g];
    end

    always_comb begin
        s_d      = s_q;
        s_d.meta = meta_d;
        s_d.sync = sync_d;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_sync = s_q.sync;

endmodule : smsp_sync

// ---- smsp_port.sv ----
// How it works
// - slave selected drives MISO only if its direction bit says output
// - slave deselect aborts shift, clears bit count, drops partial byte
// - master with select as output: select is plain output, ignored by logic
// - master with select input low: drop to slave, set done flag
// - data launched on one clock edge, captured on the opposite one
// - clock_idle_level sets idle clock level and leading edge direction
// - clock_phase_select picks sample on leading or on trailing edge
// - port_enable low means no transfers at all
// - lsb_first_select picks which end of byte goes first
// - controller_select picks master or slave role
// - interrupt when done flag, done_irq_enable and global enable all set
// - master divisor chosen by rate_double and two rate_select bits
// - rate bits ignored in slave role
// - done flag sets when a byte completes
// - done flag clears on vector taken or status read then data access
// - collision flag sets on data write during a transfer
// - status read showing collision then data access clears both flags
// - status bits five to one read zero
// - rate_double doubles master clock, shortest period two system clocks
// - master data write starts eight-bit shift, then stops and flags done
// - single transmit buffer, double receive buffer, unread byte overwritten
// - data read returns last completely received byte
//
// Added by the designer: the address-and-strobe port.
module smsp_port (
    input  wire logic                          i_clock,
    input  wire logic                          i_rst_n,
    // software register port
    input  wire logic [smsp_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic [smsp_pkg::DATA_W-1:0]   i_wdata,
    input  wire logic                          i_wr,
    input  wire logic                          i_rd,
    output logic      [smsp_pkg::DATA_W-1:0]   o_rdata,
    input  wire logic                          i_global_irq_enable,
    input  wire logic                          i_irq_ack,
    output logic                               o_irq,
    // pin directions from the port logic, one means output
    input  wire logic                          i_mosi_dir,
    input  wire logic                          i_miso_dir,
    input  wire logic                          i_sck_dir,
    input  wire logic                          i_ss_dir,
    input  wire logic                          i_ss_level,
    input  wire logic                          i_sck,
    output logic                               o_sck,
    output logic                               o_sck_oe,
    input  wire logic                          i_mosi,
    output logic                               o_mosi,
    output logic                               o_mosi_oe,
    input  wire logic                          i_miso,
    output logic                               o_miso,
    output logic                               o_miso_oe,
    input  wire logic                          i_ss_n,
    output logic                               o_ss_n,
    output logic                               o_ss_n_oe
);
    import smsp_pkg::*;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic        done;
        logic        collision;
        logic        rate_double;
        logic        arm_done;
        logic        arm_both;
        smsp_xfer_e  xfer;
        logic [7:0]  shreg;
        logic [7:0]  rxbuf;
        logic        out_bit;
        logic        sck;
        logic        sck_prev;
        logic [3:0]  edges;
        logic [3:0]  bits;
        logic [6:0]  div;
        logic [7:0]  rdata;
        logic        ss_level;
    } smsp_state_s;

    smsp_state_s s_q;
    smsp_state_s s_d;

    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins_sync;
    logic              port_en;
    logic              is_master;
    logic              idle_level;
    logic              phase;
    logic              lsb_first;
    logic              ss_low;
    logic [2:0]        rate_code;
    logic [6:0]        half_div;

    // select enters inverted: the cleared synchroniser then reads as deselected,
    // so no false selection is seen in the cycles after reset
    assign pins_raw[SYNC_SCK]  = i_sck;
    assign pins_raw[SYNC_MOSI] = i_mosi;
    assign pins_raw[SYNC_MISO] = i_miso;
    assign pins_raw[SYNC_SS]   = !i_ss_n;

    smsp_sync u_sync (
        .i_clock (i_clock),
        .i_rst_n (i_rst_n),
        .i_async (pins_raw),
        .o_sync  (pins_sync)
    );

    assign port_en    = s_q.ctrl[CTRL_PORT_EN];
    assign is_master  = s_q.ctrl[CTRL_CONTROLLER];
    assign idle_level = s_q.ctrl[CTRL_IDLE_LEVEL];
    assign phase      = s_q.ctrl[CTRL_PHASE];
    assign lsb_first  = s_q.ctrl[CTRL_LSB_FIRST];
    assign ss_low     = pins_sync[SYNC_SS];
    assign rate_code  = {s_q.rate_double, s_q.ctrl[CTRL_RATE_HIGH], s_q.ctrl[CTRL_RATE_LOW]};
    assign half_div   = HALF_DIV[rate_code];

    always_comb begin
        logic       din;
        logic       first_bit;
        logic       busy;
        logic       data_access;
        logic       done_set;
        logic       coll_set;
        logic       clr_done;
        logic       clr_coll;
        logic       rx_done;
        logic       leading;
        logic       sample_edge;
        logic       sck_now;
        din         = is_master ? pins_sync[SYNC_MISO] : pins_sync[SYNC_MOSI];
        first_bit   = lsb_first ? s_q.shreg[0] : s_q.shreg[7];
        busy        = (s_q.xfer == XFER_MASTER) ||
                      ((s_q.xfer == XFER_SLAVE) && (s_q.bits != 4'h0));
        data_access = (i_wr || i_rd) && (i_addr == ADDR_DATA);
        done_set    = 1'b0;
        coll_set    = 1'b0;
        clr_done    = 1'b0;
        clr_coll    = 1'b0;
        rx_done     = 1'b0;
        leading     = 1'b0;
        sample_edge = 1'b0;
        sck_now     = pins_sync[SYNC_SCK];

        s_d          = s_q;
        s_d.sck_prev = sck_now;
        s_d.ss_level = i_ss_level;
        s_d.rdata    = 8'h00;

        // register writes
        if (i_wr) begin
            if (i_addr == ADDR_CONTROL) begin
                s_d.ctrl = i_wdata;
            end else if (i_addr == ADDR_STATUS) begin
                s_d.rate_double = i_wdata[STAT_RATE_DOUBLE];
            end else if (i_addr == ADDR_DATA) begin
                if (busy) begin
                    // the shift register is the only transmit buffer
                    coll_set = 1'b1;
                end else begin
                    s_d.shreg   = i_wdata;
                    s_d.out_bit = lsb_first ? i_wdata[0] : i_wdata[7];
                    if (port_en && is_master) begin
                        s_d.xfer  = XFER_MASTER;
                        s_d.edges = 4'h0;
                        s_d.div   = 7'h00;
                    end
                end
            end
        end

        // register reads, answered one cycle later
        if (i_rd) begin
            if (i_addr == ADDR_CONTROL) begin
                s_d.rdata = s_q.ctrl;
            end else if (i_addr == ADDR_STATUS) begin
                s_d.rdata = {s_q.done, s_q.collision, 5'h00, s_q.rate_double};
                s_d.arm_done = s_q.done;
                s_d.arm_both = s_q.collision;
            end else if (i_addr == ADDR_DATA) begin
                s_d.rdata = s_q.rxbuf;
            end
        end

        // status read that saw a flag, then any data access, clears it
        if (data_access) begin
            clr_done     = s_q.arm_done || s_q.arm_both;
            clr_coll     = s_q.arm_both;
            s_d.arm_done = 1'b0;
            s_d.arm_both = 1'b0;
        end

        case (s_q.xfer)
            XFER_IDLE: begin
                // keep the first bit presented for a phase zero slave
                if (!busy && !(i_wr && i_addr == ADDR_DATA)) begin
                    s_d.out_bit = first_bit;
                end
                if (port_en && !is_master && ss_low) begin
                    s_d.xfer = XFER_SLAVE;
                    s_d.bits = 4'h0;
                end
            end
            XFER_MASTER: begin
                if (!port_en || !is_master) begin
                    s_d.xfer = XFER_IDLE;
                end else if (s_q.div == half_div - 7'h01) begin
                    s_d.div     = 7'h00;
                    s_d.sck     = !s_q.sck;
                    s_d.edges   = s_q.edges + 4'h1;
                    leading     = !s_q.edges[0];
                    sample_edge = leading ^ phase;
                    if (sample_edge) begin
                        s_d.shreg = lsb_first ? {din, s_q.shreg[7:1]}
                                              : {s_q.shreg[6:0], din};
                    end else begin
                        s_d.out_bit = first_bit;
                    end
                    if (s_q.edges == LAST_HALF_EDGE) begin
                        s_d.xfer = XFER_IDLE;
                        rx_done  = 1'b1;
                    end
                end else begin
                    s_d.div = s_q.div + 7'h01;
                end
            end
            XFER_SLAVE: begin
                if (!port_en || is_master || !ss_low) begin
                    s_d.xfer = XFER_IDLE;
                    s_d.bits = 4'h0;
                end else if (sck_now != s_q.sck_prev) begin
                    // the external clock is only seen through the synchroniser
                    leading     = (s_q.sck_prev == idle_level);
                    sample_edge = leading ^ phase;
                    if (sample_edge) begin
                        s_d.shreg = lsb_first ? {din, s_q.shreg[7:1]}
                                              : {s_q.shreg[6:0], din};
                        if (s_q.bits == LAST_BIT) begin
                            s_d.bits = 4'h0;
                            rx_done  = 1'b1;
                        end else begin
                            s_d.bits = s_q.bits + 4'h1;
                        end
                    end else begin
                        s_d.out_bit = first_bit;
                    end
                end
            end
            default: begin
                s_d.xfer = XFER_IDLE;
            end
        endcase

        if (s_d.xfer != XFER_MASTER) begin
            s_d.sck = idle_level;
        end

        if (rx_done) begin
            // an unread byte is simply overwritten
            s_d.rxbuf = s_d.shreg;
            done_set  = 1'b1;
        end

        // another master pulled select low while we were master
        if (port_en && is_master && !i_ss_dir && ss_low) begin
            s_d.ctrl[CTRL_CONTROLLER] = 1'b0;
            s_d.xfer                  = XFER_IDLE;
            s_d.sck                   = idle_level;
            done_set                  = 1'b1;
        end

        // a set in the same cycle as a clear wins
        s_d.done      = (s_q.done && !clr_done && !i_irq_ack) || done_set;
        s_d.collision = (s_q.collision && !clr_coll) || coll_set;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q             <= '0;
            s_q.ctrl        <= CONTROL_RESET;
            s_q.rate_double <= RATE_DOUBLE_RESET;
            s_q.shreg       <= DATA_RESET;
            s_q.rxbuf       <= DATA_RESET;
            s_q.xfer        <= XFER_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata   = s_q.rdata;
    assign o_irq     = s_q.done && s_q.ctrl[CTRL_DONE_IRQ_EN] && i_global_irq_enable;
    assign o_sck     = s_q.sck;
    assign o_mosi    = s_q.out_bit;
    assign o_miso    = s_q.out_bit;
    assign o_ss_n    = s_q.ss_level;
    // the master owns clock and data out; a slave owns only its data out
    assign o_sck_oe  = port_en && is_master && i_sck_dir;
    assign o_mosi_oe = port_en && is_master && i_mosi_dir;
    assign o_miso_oe = port_en && !is_master && ss_low && i_miso_dir;
    assign o_ss_n_oe = port_en && is_master && i_ss_dir;

endmodule : smsp_port

// ---- smsp_port_monitor.sv ----
module smsp_port_monitor (
    input wire logic                        i_clock,
    input wire logic                        i_rst_n,
    input wire logic [smsp_pkg::ADDR_W-1:0] i_addr,
    input wire logic                        i_rd,
    input wire logic [smsp_pkg::DATA_W-1:0] o_rdata,
    input wire logic                        i_global_irq_enable,
    input wire logic                        i_irq_ack,
    input wire logic                        o_irq,
    input wire logic                        i_mosi_dir,
    input wire logic                        i_miso_dir,
    input wire logic                        i_sck_dir,
    input wire logic                        i_ss_dir,
    input wire logic                        i_ss_level,
    input wire logic                        i_ss_n,
    input wire logic                        o_sck_oe,
    input wire logic                        o_mosi_oe,
    input wire logic                        o_miso_oe,
    input wire logic                        o_ss_n,
    input wire logic                        o_ss_n_oe
);
    import smsp_pkg::*;

    default clocking mon_cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    reserved_zero_a: assert property (
        $past(i_rd) && $past(i_addr) == ADDR_STATUS |-> o_rdata[5:1] == 5'h00)
        else $error("reserved status bits not zero");
    irq_gate_a: assert property (!i_global_irq_enable |-> !o_irq)
        else $error("interrupt while globally masked");
    irq_ack_a: assert property (i_irq_ack |=> !o_irq)
        else $error("done flag survived vector taken");
    pin_dir_a: assert property ((o_sck_oe |-> i_sck_dir) and (o_mosi_oe |-> i_mosi_dir)
        and (o_miso_oe |-> i_miso_dir))
        else $error("pin driven against its direction");
    role_excl_a: assert property (o_miso_oe |-> !o_sck_oe && !o_mosi_oe && !o_ss_n_oe)
        else $error("slave and master pins driven together");
    selected_drive_a: assert property (
        o_miso_oe |-> !$past(i_ss_n, 2) || !$past(i_ss_n, 3))
        else $error("slave drives data without being selected");
    deselect_quiet_a: assert property (i_ss_n [*4] |-> !o_miso_oe)
        else $error("deselected slave still drives");
    fault_drop_a: assert property (
        o_sck_oe && !i_ss_dir && !i_ss_n |-> ##[1:4] !o_sck_oe)
        else $error("master kept clock after select pulled low");
    ss_plain_a: assert property (
        o_ss_n_oe && $past(o_ss_n_oe) |-> o_ss_n == $past(i_ss_level))
        else $error("select pin does not follow its level");
endmodule : smsp_port_monitor

// ---- smsp_spi_peer.sv ----
module smsp_spi_peer (
    input  wire logic       i_sck,
    input  wire logic       i_mosi,
    input  wire logic       i_ss_n,
    input  wire logic       i_clock_idle_level,
    input  wire logic       i_clock_phase_select,
    input  wire logic       i_lsb,
    input  wire logic [7:0] i_tx,
    output logic            o_miso,
    output logic      [7:0] o_rx
);
    timeunit 1ns;
    timeprecision 1ps;

    int         setups;
    logic       bit_q;
    logic [2:0] k;

    initial begin
        setups = 0;
        o_rx   = 8'h00;
        bit_q  = 1'b0;
    end

    always @(negedge i_ss_n) begin
        setups = 0;
        o_rx   = 8'h00;
    end

    // leading edge leaves the idle level; phase says which edge samples
    always @(i_sck) begin
        if (!i_ss_n) begin
            if ((i_sck != i_clock_idle_level) != i_clock_phase_select) begin
                o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
            end else begin
                setups++;
            end
        end
    end

    always @* begin
        k = 3'((i_clock_phase_select && setups > 0) ? setups - 1 : setups);
        if (!i_ss_n) begin
            bit_q = i_tx[i_lsb ? k : 3'd7 - k];
        end
    end

    // a released line must not look like a held copy of the last bit
    assign o_miso = i_ss_n ? ~bit_q : bit_q;
endmodule : smsp_spi_peer

// ---- smsp_port_tb.sv ----
module smsp_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import smsp_pkg::*;

    logic        clock, rst_n, wr, rd, gie, ack, ss_n, ss_dir, miso_dir, ss_level;
    logic        irq, sck, mosi, miso, ss_out, lsb, clock_idle_level, clock_phase_select;
    logic        sck_in, mosi_in, slv_miso;
    logic [7:0]  addr, wdata, rdata, peer_tx, peer_rx, miso_seen;
    int          errors, tests_run, n;
    int          div [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
    // row: {lsb first, mode, byte the port sends, byte the peer sends}
    logic [18:0] rows [4] = '{19'h0a53c, 19'h181e7, 19'h65ac3, 19'h70f96};

    smsp_port u_dut (.i_clock(clock), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_global_irq_enable(gie), .i_irq_ack(ack),
        .o_irq(irq), .i_mosi_dir(1'b1), .i_miso_dir(miso_dir), .i_sck_dir(1'b1),
        .i_ss_dir(ss_dir), .i_ss_level(ss_level), .i_sck(sck_in), .o_sck(sck), .o_sck_oe(),
        .i_mosi(mosi_in), .o_mosi(mosi), .o_mosi_oe(), .i_miso(miso),
        .o_miso(slv_miso), .o_miso_oe(),
        .i_ss_n(ss_n), .o_ss_n(ss_out), .o_ss_n_oe());

    smsp_spi_peer u_peer (.i_sck(sck), .i_mosi(mosi), .i_ss_n(ss_out), .i_clock_idle_level(clock_idle_level),
        .i_clock_phase_select(clock_phase_select), .i_lsb(lsb), .i_tx(peer_tx), .o_miso(miso), .o_rx(peer_rx));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1 chk(nm, {8'h00, e}, {8'h00, rdata});
    endtask : rd_chk

    task automatic wait_irq;
        n = 0;
        do begin
            @(posedge clock);
            #1 n++;
        end while (irq !== 1'b1 && n < 3000);
        if (irq !== 1'b1) begin
            errors++;
            $display("[ERR] irq expected 1 seen 0");
        end
    endtask : wait_irq

    task automatic pulse_ack;
        @(posedge clock);
        ack <= 1'b1;
        @(posedge clock);
        ack <= 1'b0;
        #1 chk("irq_after_ack", 16'h0000, {15'h0, irq});
    endtask : pulse_ack

    // outside master in mode 0, msb first, five system clocks per clock phase
    task automatic slave_shift(input logic [7:0] m, input int nb);
        for (int b = 7; b > 7 - nb; b--) begin
            mosi_in <= m[b];
            repeat (5) @(posedge clock);
            miso_seen <= {miso_seen[6:0], slv_miso};
            sck_in    <= 1'b1;
            repeat (5) @(posedge clock);
            sck_in    <= 1'b0;
        end
    endtask : slave_shift

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    initial begin
        rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00; gie = 1'b1;
        ack = 1'b0; ss_n = 1'b1; ss_dir = 1'b1; miso_dir = 1'b0; ss_level = 1'b1;
        lsb = 1'b0; clock_idle_level = 1'b0; clock_phase_select = 1'b0; peer_tx = 8'h00; errors = 0; tests_run = 0;
        sck_in = 1'b0;
        mosi_in = 1'b0;
        miso_seen = 8'h00;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd_chk(ADDR_CONTROL, 8'h00, "control_reset");
        rd_chk(ADDR_STATUS, 8'h00, "status_reset");
        wr_reg(ADDR_STATUS, 8'hff);
        rd_chk(ADDR_STATUS, 8'h01, "status_reserved");
        rd_chk(8'h30, 8'h00, "unmapped_read");
        $display("test registers done");
        for (int r = 0; r < 8; r++) begin
            wr_reg(ADDR_STATUS, {7'h00, r[2]});
            wr_reg(ADDR_CONTROL, {6'h34, r[1:0]});
            wr_reg(ADDR_DATA, 8'h55);
            wait_irq;
            chk("done_cycles", 16'(div[r] * 8), 16'(n));
            pulse_ack;
        end
        wr_reg(ADDR_STATUS, 8'h00);
        $display("test rates done");
        for (int i = 0; i < 4; i++) begin
            wr_reg(ADDR_CONTROL, {2'b11, rows[i][18], 1'b1, rows[i][17:16], 2'b01});
            {lsb, clock_idle_level, clock_phase_select} <= rows[i][18:16];
            peer_tx <= rows[i][7:0];
            @(posedge clock);
            ss_level <= 1'b0;
            wr_reg(ADDR_DATA, rows[i][15:8]);
            wait_irq;
            rd_chk(ADDR_STATUS, 8'h80, "status_done");
            rd_chk(ADDR_DATA, rows[i][7:0], "rx_byte");
            chk("irq_after_data", 16'h0000, {15'h0, irq});
            chk("peer_rx", {8'h00, rows[i][15:8]}, {8'h00, peer_rx});
            chk("sck_idle", {15'h0, clock_idle_level}, {15'h0, sck});
            ss_level <= 1'b1;
        end
        $display("test modes done");
        @(posedge clock);
        ss_level <= 1'b0;
        wr_reg(ADDR_DATA, 8'h11);
        repeat (20) @(posedge clock);
        wr_reg(ADDR_DATA, 8'h22);
        wait_irq;
        rd_chk(ADDR_STATUS, 8'hc0, "collision_set");
        rd_chk(ADDR_DATA, 8'h96, "rx_kept");
        rd_chk(ADDR_STATUS, 8'h00, "flags_cleared");
        chk("peer_rx_first", 16'h0011, {8'h00, peer_rx});
        ss_level <= 1'b1;
        $display("test collision done");
        wr_reg(ADDR_CONTROL, 8'h91);
        wr_reg(ADDR_DATA, 8'h33);
        repeat (300) @(posedge clock);
        rd_chk(ADDR_STATUS, 8'h00, "disabled_idle");
        $display("test disabled done");
        ss_dir <= 1'b0;
        wr_reg(ADDR_CONTROL, 8'hd1);
        ss_n <= 1'b0;
        miso_dir <= 1'b1;
        repeat (8) @(posedge clock);
        rd_chk(ADDR_CONTROL, 8'hc1, "fault_role");
        chk("fault_irq", 16'h0001, {15'h0, irq});
        @(posedge clock);
        gie <= 1'b0;
        @(posedge clock);
        #1 chk("irq_masked", 16'h0000, {15'h0, irq});
        @(posedge clock);
        gie <= 1'b1;
        ss_n <= 1'b1;
        repeat (8) @(posedge clock);
        rd_chk(ADDR_CONTROL, 8'hc1, "stays_slave");
        pulse_ack;
        $display("test mode fault done");
        wr_reg(ADDR_DATA, 8'hc3);
        ss_n <= 1'b0;
        repeat (6) @(posedge clock);
        slave_shift(8'h0f, 3);
        ss_n <= 1'b1;
        repeat (6) @(posedge clock);
        rd_chk(ADDR_STATUS, 8'h00, "partial_no_done");
        wr_reg(ADDR_DATA, 8'hc3);
        ss_n <= 1'b0;
        repeat (6) @(posedge clock);
        slave_shift(8'ha6, 8);
        ss_n <= 1'b1;
        chk("slave_miso", 16'h00c3, {8'h00, miso_seen});
        rd_chk(ADDR_STATUS, 8'h80, "slave_done");
        rd_chk(ADDR_DATA, 8'ha6, "slave_rx");
        $display("test slave done");
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd_chk(ADDR_CONTROL, 8'h00, "control_rereset");
        $display("test reset done");
        end_of_test;
    end

    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        $display("[ERR] watchdog expected finish seen hang");
        end_of_test;
    end
endmodule : smsp_port_tb

bind smsp_port smsp_port_monitor u_mon (.*);
